/* File: design/mss_top.sv */
// Purpose: Motor state, stall and phase sequence supervision
// Assumes: Current inputs from same-clock front end
// Notes:   One millisecond tick drives all timing
`timescale 1ns/10ps
module mss_top import mss_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int FORCE_TIMEOUT_MS = FORCE_TICKS
) (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic [15:0] avg_current_in,
   input  wire logic [7:0]  neg_to_pos_sequence_ratio_in,
   input  wire logic        unb_fault_in,
   input  wire logic [15:0] unb_peak_in,
   input  wire logic [7:0]  unb_elapsed_delay_pct_in,
   input  wire logic [31:0] time_stamp_in,
   input  wire logic        panel_press_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   output logic             motor_starting_out,
   output logic             motor_running_out,
   output logic             stall_start_out,
   output logic             stall_trip_out,
   output logic             seq_start_out,
   output logic             seq_trip_out,
   output logic             force_active_out
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0]       tick_cnt;
      mss_state_t        st;
      logic [15:0]       stop_ms;
      logic [15:0]       win_ms;
      logic              armed;
      logic [5:0]        ctrl;
      logic [15:0]       det;
      logic [15:0]       rated;
      logic [23:0]       tdef;
      logic [23:0]       inverse_time_multiplier;
      logic [15:0]       ct;
      logic              stall_st;
      logic              stall_tr;
      logic [31:0]       stall_ms;
      logic [7:0]        stall_pct;
      logic              seq_st;
      logic              seq_tr;
      logic [15:0]       seq_ms;
      logic [15:0]       s_starts;
      logic [15:0]       s_trips;
      logic [15:0]       q_starts;
      logic [15:0]       q_trips;
      logic [15:0]       s_flt;
      logic [7:0]        q_flt;
      logic              force_on;
      logic [31:0]       force_ms;
      logic [2:0]        press_s;
      logic [2:0]        wptr;
      logic [2:0]        lsel;
      logic [7:0][31:0]  ltime;
      logic [7:0][25:0]  linfo;
      logic [31:0]       rdata;
      logic [6:0]        outs;
   } mss_regs_t;

   mss_regs_t q;
   mss_regs_t d;

   logic        tick;
   logic        below;
   logic        run_ok;
   logic        above_det;
   logic        press;
   logic        seq_cond;
   logic [55:0] inv_num;
   logic [31:0] inv_den;
   logic [55:0] inv_t;
   logic [31:0] op_t;
   logic [39:0] pct_raw;
   logic [31:0] prim_det;
   logic [31:0] prim_rat;

   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   always_comb begin
      tick = (q.tick_cnt == 32'(TICK_CYCLES - 1));
      below = avg_current_in < LVL_STOP; // R10
      run_ok = (avg_current_in >= LVL_RUNLO) && (avg_current_in <= LVL_RUNHI); // R13
      above_det = avg_current_in > q.det; // R9
      press = q.press_s[1] & ~q.press_s[2];
      seq_cond = (q.st == MSS_STARTING) && (neg_to_pos_sequence_ratio_in > RATIO_SEQ)
                 && (avg_current_in > LVL_SEQ); // R1
      inv_num = 56'(q.inverse_time_multiplier) * 56'(q.rated) * 56'(q.rated); // R7
      inv_den = 32'(avg_current_in) * 32'(avg_current_in);
      inv_t = (inv_den == 32'h00000000) ? 56'(CAP_MS) : inv_num / 56'(inv_den);
      if (!q.ctrl[C_INV]) begin // R6
         op_t = 32'(q.tdef);
      end else if (inv_t > 56'(CAP_MS)) begin
         op_t = CAP_MS; // R23
      end else begin
         op_t = inv_t[31:0];
      end
      if (op_t == 32'h00000000) begin
         op_t = 32'h00000001;
      end
      pct_raw = (40'(q.stall_ms) * 40'(PCT_FULL)) / 40'(op_t); // R17
      prim_det = 32'(q.det) * 32'(q.ct) / PCT_FULL; // R20
      prim_rat = 32'(q.rated) * 32'(q.ct) / PCT_FULL; // R20
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.tick_cnt = tick ? 32'h00000000 : q.tick_cnt + 32'h00000001;
      d.press_s = {q.press_s[1:0], panel_press_in};
      // Motor state tracker
      case (q.st)
         MSS_STOPPED: begin
            if (below) begin
               d.win_ms = 16'h0000;
               if (tick && q.stop_ms < STOP_MS) begin
                  d.stop_ms = q.stop_ms + 16'h0001;
               end
               d.armed = (q.stop_ms >= STOP_MS); // R11
            end else begin
               d.stop_ms = 16'h0000;
               if (tick && q.win_ms < WIN_MS) begin
                  d.win_ms = q.win_ms + 16'h0001;
               end
               if (q.armed && above_det && q.win_ms < WIN_MS) begin
                  d.st = MSS_STARTING; // R11
                  d.stall_st = 1'b1; // R3
                  d.stall_ms = 32'h00000000;
                  d.s_starts = q.s_starts + 16'h0001; // R18
                  d.armed = 1'b0;
               end else if (run_ok) begin
                  d.st = MSS_RUNNING; // R14
                  d.armed = 1'b0;
               end else if (q.win_ms >= WIN_MS) begin
                  d.armed = 1'b0; // R3
               end
            end
         end
         MSS_STARTING: begin
            if (below) begin
               d.st = MSS_STOPPED; // R10
            end else if (run_ok) begin
               d.st = MSS_RUNNING; // R12
            end
         end
         MSS_RUNNING: begin
            if (below) begin
               d.st = MSS_STOPPED; // R10
            end
         end
         default: begin
            d.st = MSS_STOPPED;
         end
      endcase
      if (d.st != MSS_STOPPED) begin
         d.stop_ms = 16'h0000;
         d.win_ms = 16'h0000;
      end
      // Stall stage
      if (q.stall_st) begin
         if (q.st != MSS_STARTING || avg_current_in < LVL_RUNHI) begin
            d.stall_st = 1'b0; // R4 R5
            d.stall_tr = 1'b0;
            d.stall_ms = 32'h00000000;
         end else begin
            if (tick && !q.stall_tr) begin
               d.stall_ms = q.stall_ms + 32'h00000001;
            end
            if (avg_current_in > q.s_flt) begin
               d.s_flt = avg_current_in; // R18
            end
            if (!q.stall_tr && q.stall_ms >= op_t) begin
               d.stall_tr = 1'b1; // R22
               d.s_trips = q.s_trips + 16'h0001; // R18
            end
            d.stall_pct = (pct_raw > 40'(PCT_FULL)) ? PCT_FULL[7:0] : pct_raw[7:0];
         end
      end
      // Phase sequence stage
      if (seq_cond) begin
         if (!q.seq_st) begin
            d.q_starts = q.q_starts + 16'h0001; // R18
            d.seq_ms = 16'h0000;
         end
         d.seq_st = 1'b1; // R1
         if (neg_to_pos_sequence_ratio_in > q.q_flt) begin
            d.q_flt = neg_to_pos_sequence_ratio_in; // R18
         end
         if (tick && q.seq_st && q.seq_ms < SEQ_MS) begin
            d.seq_ms = q.seq_ms + 16'h0001;
         end
         if (q.seq_st && !q.seq_tr && q.seq_ms >= SEQ_MS) begin
            d.seq_tr = 1'b1; // R2
            d.q_trips = q.q_trips + 16'h0001;
         end
      end else begin
         d.seq_st = 1'b0;
         d.seq_tr = 1'b0;
         d.seq_ms = 16'h0000;
      end
      // Force flag timeout, restarted by any panel press
      if (q.force_on && tick) begin
         d.force_ms = q.force_ms + 32'h00000001;
      end
      if (press) begin
         d.force_ms = 32'h00000000;
      end
      if (q.force_on && q.force_ms >= 32'(FORCE_TIMEOUT_MS)) begin
         d.force_on = 1'b0; // R19
      end
      // Fault log of unbalance stage
      if (unb_fault_in) begin
         d.ltime[q.wptr] = time_stamp_in; // R16
         d.linfo[q.wptr] = {q.ctrl[C_GRP +: 2], unb_elapsed_delay_pct_in, unb_peak_in};
         d.wptr = q.wptr + 3'h1;
      end
      // Register writes
      if (wr_in) begin
         case (addr_in)
            A_CTRL: begin
               d.ctrl = wdata_in[5:0];
               d.ctrl[C_FSET] = 1'b0;
               if (wdata_in[C_FSET]) begin
                  d.force_on = 1'b1;
                  d.force_ms = 32'h00000000;
               end
            end
            A_DET:   d.det = wdata_in[15:0]; // R9
            A_RATED: d.rated = wdata_in[15:0];
            A_TDEF:  d.tdef = wdata_in[23:0];
            A_INVERSE_TIME_MULTIPLIER:  d.inverse_time_multiplier = wdata_in[23:0];
            A_CT:    d.ct = wdata_in[15:0];
            A_SCNT: begin
               d.s_starts = 16'h0000;
               d.s_trips = 16'h0000;
            end
            A_QCNT: begin
               d.q_starts = 16'h0000;
               d.q_trips = 16'h0000;
            end
            A_FLT: begin
               d.s_flt = 16'h0000;
               d.q_flt = 8'h00;
            end
            A_LSEL:  d.lsel = wdata_in[2:0];
            default: d.lsel = d.lsel;
         endcase
      end
      // Register reads, data in the following cycle
      d.rdata = 32'h00000000;
      if (rd_in) begin
         case (addr_in)
            A_CTRL:  d.rdata = {26'h0000000, q.ctrl};
            A_DET:   d.rdata = {16'h0000, q.det};
            A_RATED: d.rdata = {16'h0000, q.rated};
            A_TDEF:  d.rdata = {8'h00, q.tdef};
            A_INVERSE_TIME_MULTIPLIER:  d.rdata = {8'h00, q.inverse_time_multiplier};
            A_CT:    d.rdata = {16'h0000, q.ct};
            A_STAT:  d.rdata = {25'h0000000, q.force_on, q.seq_tr, q.seq_st,
                                q.stall_tr, q.stall_st, q.st};
            A_SCNT:  d.rdata = {q.s_trips, q.s_starts};
            A_QCNT:  d.rdata = {q.q_trips, q.q_starts};
            A_FLT:   d.rdata = {8'h00, q.q_flt, q.s_flt};
            A_ELAPSED_DELAY_PCT:  d.rdata = {16'h0000, (q.seq_tr ? PCT_FULL[7:0] : q.seq_ms[7:0]),
                                q.stall_pct}; // R17
            A_PRIM:  d.rdata = {prim_rat[15:0], prim_det[15:0]}; // R20
            A_LSEL:  d.rdata = {26'h0000000, q.wptr, q.lsel};
            A_LTIME: d.rdata = q.ltime[q.lsel];
            A_LINFO: d.rdata = {6'h00, q.linfo[q.lsel]};
            default: d.rdata = 32'h00000000;
         endcase
      end
      // Outputs; forcing only while the shared flag is on
      d.outs = {d.force_on,
                d.seq_tr | (d.force_on & d.ctrl[C_FSEQ]),
                d.seq_st,
                d.stall_tr | (d.force_on & d.ctrl[C_FSTALL]),
                d.stall_st,
                d.st == MSS_RUNNING,
                d.st == MSS_STARTING}; // R15
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= '0;
         q.st <= MSS_STOPPED;
         q.det <= DET_RST; // R9
         q.rated <= RATED_RST; // R8
         q.tdef <= TDEF_RST;
         q.inverse_time_multiplier <= INVERSE_TIME_MULTIPLIER_RST;
         q.ct <= CT_RST;
      end else begin
         q <= d;
      end
   end

   assign rdata_out = q.rdata;
   assign motor_starting_out = q.outs[0];
   assign motor_running_out = q.outs[1];
   assign stall_start_out = q.outs[2];
   assign stall_trip_out = q.outs[3];
   assign seq_start_out = q.outs[4];
   assign seq_trip_out = q.outs[5];
   assign force_active_out = q.outs[6];
endmodule // mss_top

/* File: design/mss_pkg.sv */
// Purpose: Constants for motor start supervision
// Assumes: Currents in percent of motor nominal, ratio in percent
// Notes:   Times counted in one millisecond ticks
// Operation
// R1: Phase stage starts: ratio>80%, mean>0.2.
// R2: Phase stage trips 100 ms after start.
// R3: Stall timing needs low-then-high within 200 ms.
// R4: Stall releases below 120% nominal.
// R5: Stall acts only while motor starting.
// R6: Stall offers fixed or inverse characteristic.
// R7: Inverse time: multiplier times (rated/measured) squared.
// R8: Rated start current resets to 6.00.
// R9: Start detection default 6, writable.
// R10: Stopped whenever average below 10%.
// R11: Starting needs 500 ms stopped, 200 ms rise.
// R12: Starting holds until running conditions met.
// R13: Running when average within 20..120%.
// R14: Soft start goes stopped to running directly.
// R15: Starting and running exported as outputs.
// R16: Keep eight latest unbalance fault records.
// R17: Elapsed delay in percent, 100 = trip.
// R18: Start, trip counters and maximum fault current.
// R19: Force flag clears 5 minutes after press.
// R20: Primary amperes computed from per-unit settings.
// R21: Detection level must stay below start current; not enforced, both reset to 6.00.
// R22: Stall trips when elapsed reaches operate time.
// R23: Inverse delay capped at 1000 seconds.
package mss_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_DET   = 8'h04;
   localparam logic [7:0] A_RATED = 8'h08;
   localparam logic [7:0] A_TDEF  = 8'h0C;
   localparam logic [7:0] A_INVERSE_TIME_MULTIPLIER  = 8'h10;
   localparam logic [7:0] A_CT    = 8'h14;
   localparam logic [7:0] A_STAT  = 8'h18;
   localparam logic [7:0] A_SCNT  = 8'h1C;
   localparam logic [7:0] A_QCNT  = 8'h20;
   localparam logic [7:0] A_FLT   = 8'h24;
   localparam logic [7:0] A_ELAPSED_DELAY_PCT  = 8'h28;
   localparam logic [7:0] A_PRIM  = 8'h2C;
   localparam logic [7:0] A_LSEL  = 8'h30;
   localparam logic [7:0] A_LTIME = 8'h34;
   localparam logic [7:0] A_LINFO = 8'h38;
   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   localparam int C_INV = 0;
   localparam int C_FSET = 1;
   localparam int C_FSTALL = 2;
   localparam int C_FSEQ = 3;
   localparam int C_GRP = 4;
   // ----------------------------------------------------------------
   // Levels in percent of nominal, and reset values of the settings
   // ----------------------------------------------------------------
   localparam logic [15:0] LVL_STOP = 16'h000A;
   localparam logic [15:0] LVL_RUNLO = 16'h0014;
   localparam logic [15:0] LVL_RUNHI = 16'h0078;
   localparam logic [15:0] LVL_SEQ = 16'h0014;
   localparam logic [7:0]  RATIO_SEQ = 8'h50;
   localparam logic [15:0] DET_RST = 16'h0258;
   localparam logic [15:0] RATED_RST = 16'h0258;
   localparam logic [23:0] TDEF_RST = 24'h0003E8;
   localparam logic [23:0] INVERSE_TIME_MULTIPLIER_RST = 24'h002710;
   localparam logic [15:0] CT_RST = 16'h0064;
   localparam logic [31:0] PCT_FULL = 32'h00000064;
   // ----------------------------------------------------------------
   // Times
   // ----------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam logic [15:0] STOP_MS = 16'h01F4;
   localparam logic [15:0] WIN_MS = 16'h00C8;
   localparam logic [15:0] SEQ_MS = 16'h0064;
   localparam int FORCE_MIN = 5;
   localparam int FORCE_TICKS = FORCE_MIN * 60 * 1000;
   localparam int CAP_S = 1000;
   localparam logic [31:0] CAP_MS = 32'(CAP_S * 1000);
   typedef enum logic [1:0] {MSS_STOPPED, MSS_STARTING, MSS_RUNNING} mss_state_t;
endpackage

/* File: test/mss_sva.sv */
// Purpose: Port checks for motor start supervision
// Assumes: Short tick and force timeout passed by bind
// Notes:   Levels in percent of motor nominal
`timescale 1ns/10ps
module mss_sva import mss_pkg::*; #(
   parameter int TICK_CYCLES      = 10,
   parameter int FORCE_TIMEOUT_MS = 20
) (
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic [15:0] avg_current_in,
   input wire logic [7:0]  neg_to_pos_sequence_ratio_in,
   input wire logic        panel_press_in,
   input wire logic        motor_starting_out,
   input wire logic        motor_running_out,
   input wire logic        stall_start_out,
   input wire logic        stall_trip_out,
   input wire logic        seq_start_out,
   input wire logic        seq_trip_out,
   input wire logic        force_active_out
);
   // Two ticks of slack below and three above for tick phase
   localparam int SEQ_LO = 98 * TICK_CYCLES;
   localparam int SEQ_HI = 103 * TICK_CYCLES;
   localparam int F_MAX  = (FORCE_TIMEOUT_MS + 2) * TICK_CYCLES + 8;
   logic [31:0] seq_cnt_q;
   logic [31:0] frc_cnt_q;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         seq_cnt_q <= 32'h0;
         frc_cnt_q <= 32'h0;
      end else begin
         seq_cnt_q <= seq_start_out ? seq_cnt_q + 32'h1 : 32'h0;
         frc_cnt_q <= (force_active_out && !panel_press_in) ? frc_cnt_q + 32'h1 : 32'h0;
      end
   end
   property p_excl; !(motor_starting_out && motor_running_out); endproperty
   a_excl: assert property (p_excl) else $error("starting and running both set");
   property p_stop; (avg_current_in < LVL_STOP)[*3] |=> !motor_running_out && !motor_starting_out;
   endproperty
   a_stop: assert property (p_stop) else $error("not stopped at low current");
   property p_from_stop; $rose(motor_starting_out) |-> !$past(motor_running_out); endproperty
   a_from_stop: assert property (p_from_stop) else $error("start from running");
   property p_stall_win; stall_start_out |-> motor_starting_out || $past(motor_starting_out);
   endproperty
   a_stall_win: assert property (p_stall_win) else $error("stall outside starting");
   property p_stall_rel; (avg_current_in < LVL_RUNHI && !force_active_out)[*3] |=> !stall_start_out;
   endproperty
   a_stall_rel: assert property (p_stall_rel) else $error("stall not released");
   property p_stall_trip; $rose(stall_trip_out) && !force_active_out |-> stall_start_out;
   endproperty
   a_stall_trip: assert property (p_stall_trip) else $error("stall trip without start");
   property p_seq_cond; $rose(seq_start_out) |-> $past(neg_to_pos_sequence_ratio_in) > RATIO_SEQ
      && $past(avg_current_in) > LVL_SEQ; endproperty
   a_seq_cond: assert property (p_seq_cond) else $error("sequence start bad cause");
   property p_seq_early; $rose(seq_trip_out) && !force_active_out |-> seq_cnt_q >= SEQ_LO;
   endproperty
   a_seq_early: assert property (p_seq_early) else $error("sequence trip early");
   property p_seq_late; seq_cnt_q == SEQ_HI |-> seq_trip_out; endproperty
   a_seq_late: assert property (p_seq_late) else $error("sequence trip late");
   property p_force; frc_cnt_q <= F_MAX; endproperty
   a_force: assert property (p_force) else $error("force flag outlived timeout");
endmodule // mss_sva
bind mss_top mss_sva #(.TICK_CYCLES(TICK_CYCLES), .FORCE_TIMEOUT_MS(FORCE_TIMEOUT_MS))
   mss_sva_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .avg_current_in(avg_current_in),
   .neg_to_pos_sequence_ratio_in(neg_to_pos_sequence_ratio_in),
   .panel_press_in(panel_press_in), .motor_starting_out(motor_starting_out),
   .motor_running_out(motor_running_out), .stall_start_out(stall_start_out),
   .stall_trip_out(stall_trip_out), .seq_start_out(seq_start_out),
   .seq_trip_out(seq_trip_out), .force_active_out(force_active_out));

/* File: test/mss_front.sv */
// Purpose: Measurement front end model
// Assumes: Bench sets target levels
// Notes:   Outputs move just after an edge
`timescale 1ns/10ps
module mss_front (
   input  wire logic        clk_in,
   input  wire logic [15:0] lvl_in,
   input  wire logic [7:0]  ratio_in,
   output logic      [15:0] avg_current_out,
   output logic      [7:0]  ratio_out
);
   // Level and ratio passed through one register stage, unchanged
   always @(posedge clk_in) begin
      avg_current_out <= lvl_in;
      ratio_out <= ratio_in;
   end
endmodule // mss_front

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for motor start supervision
// Assumes: Tick of 10 clocks, force timeout 20 ticks
// Notes:   One task per scenario
`timescale 1ns/10ps
module tb_top;
   import mss_pkg::*;
   localparam int TK = 10;
   logic        clk_in;
   logic        rst_b_in;
   logic [15:0] lvl;
   logic [7:0]  ratio;
   logic [15:0] avg;
   logic [7:0]  rat;
   logic        unb_fault;
   logic [15:0] unb_peak;
   logic [7:0]  unb_elapsed_delay_pct;
   logic [31:0] tstamp;
   logic        panel;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        m_st, m_run, s_st, s_tr, q_st, q_tr, frc;
   int          fails;
   int          n_tests;
   mss_front mss_front_i (.clk_in(clk_in), .lvl_in(lvl), .ratio_in(ratio),
      .avg_current_out(avg), .ratio_out(rat));
   mss_top #(.TICK_CYCLES(TK), .FORCE_TIMEOUT_MS(20)) mss_top_i (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .avg_current_in(avg), .neg_to_pos_sequence_ratio_in(rat),
      .unb_fault_in(unb_fault), .unb_peak_in(unb_peak), .unb_elapsed_delay_pct_in(unb_elapsed_delay_pct),
      .time_stamp_in(tstamp), .panel_press_in(panel), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .motor_starting_out(m_st),
      .motor_running_out(m_run), .stall_start_out(s_st), .stall_trip_out(s_tr),
      .seq_start_out(q_st), .seq_trip_out(q_tr), .force_active_out(frc));
   task automatic cnt(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chb(input string nm, input logic e, input logic g);
      cnt(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk_in);
      wr <= 1'h0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk_in);
      rd <= 1'h0;
      #1;
      cnt(nm, e, rdata);
   endtask
   // Front end levels change on an edge, then n ticks pass
   task automatic go(input logic [15:0] l, input logic [7:0] r, input int n);
      @(posedge clk_in);
      lvl <= l;
      ratio <= r;
      repeat (n * TK) @(posedge clk_in);
      #1;
   endtask
   task automatic t_regs();
      rd_reg(A_DET, 32'h258, "det");
      rd_reg(A_RATED, 32'h258, "rated");
      rd_reg(A_TDEF, 32'h3E8, "tdef");
      rd_reg(A_STAT, 32'h0, "stat");
      rd_reg(8'hFC, 32'h0, "unmapped");
      wr_reg(A_DET, 32'h2BC);
      rd_reg(A_DET, 32'h2BC, "det wr");
      wr_reg(A_DET, 32'h258);
      wr_reg(A_CT, 32'hC8);
      rd_reg(A_PRIM, 32'h04B004B0, "primary");
      $display("done regs");
   endtask
   task automatic t_fixed();
      wr_reg(A_TDEF, 32'h96);
      go(16'h0, 8'h0, 510);
      go(16'h2BC, 8'h5A, 125);
      chb("starting", 1'h1, m_st);
      chb("seq trip", 1'h1, q_tr);
      chb("stall trip", 1'h0, s_tr);
      chb("stall start", 1'h1, s_st);
      chb("seq start", 1'h1, q_st);
      rd_reg(A_STAT, 32'h35, "stat");
      go(16'h2BC, 8'h5A, 35);
      chb("stall trip", 1'h1, s_tr);
      rd_reg(A_SCNT, 32'h10001, "stall cnt");
      rd_reg(A_QCNT, 32'h10001, "seq cnt");
      rd_reg(A_ELAPSED_DELAY_PCT, 32'h6464, "elapsed");
      rd_reg(A_FLT, 32'h005A02BC, "max fault");
      go(16'h64, 8'h0, 2);
      chb("running", 1'h1, m_run);
      chb("stall start", 1'h0, s_st);
      $display("done fixed");
   endtask
   task automatic t_inverse();
      wr_reg(A_CTRL, 32'h1);
      wr_reg(A_INVERSE_TIME_MULTIPLIER, 32'h14);
      rd_reg(A_CTRL, 32'h1, "ctrl inv");
      rd_reg(A_INVERSE_TIME_MULTIPLIER, 32'h14, "inverse_time_multiplier");
      go(16'h0, 8'h0, 510);
      go(16'h4B0, 8'h0, 3);
      chb("inv early", 1'h0, s_tr);
      go(16'h4B0, 8'h0, 5);
      chb("inv trip", 1'h1, s_tr);
      go(16'h64, 8'h0, 2);
      $display("done inverse");
   endtask
   task automatic t_soft();
      go(16'h0, 8'h0, 100);
      go(16'h2BC, 8'h0, 3);
      chb("short stop", 1'h0, m_st);
      go(16'h0, 8'h0, 510);
      chb("stopped", 1'h0, m_run);
      go(16'h64, 8'h0, 3);
      chb("soft run", 1'h1, m_run);
      chb("soft start", 1'h0, m_st);
      rd_reg(A_SCNT, 32'h20002, "stall cnt");
      wr_reg(A_SCNT, 32'h0);
      rd_reg(A_SCNT, 32'h0, "cnt clear");
      $display("done soft");
   endtask
   task automatic t_log();
      wr_reg(A_CTRL, 32'h20);
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_in);
         unb_fault <= 1'h1;
         unb_peak <= 16'(i + 1);
         unb_elapsed_delay_pct <= 8'(i);
         tstamp <= 32'h100 + 32'(i);
         @(posedge clk_in);
         unb_fault <= 1'h0;
      end
      rd_reg(A_LSEL, 32'h8, "log ptr");
      rd_reg(A_LTIME, 32'h108, "log time");
      rd_reg(A_LINFO, 32'h02080009, "log info");
      $display("done log");
   endtask
   task automatic t_force();
      wr_reg(A_CTRL, 32'h2E);
      rd_reg(A_CTRL, 32'h2C, "ctrl force");
      go(16'h64, 8'h0, 10);
      chb("force", 1'h1, frc);
      chb("forced stall", 1'h1, s_tr);
      chb("forced seq", 1'h1, q_tr);
      @(posedge clk_in);
      panel <= 1'h1;
      repeat (3) @(posedge clk_in);
      panel <= 1'h0;
      go(16'h64, 8'h0, 15);
      chb("force held", 1'h1, frc);
      go(16'h64, 8'h0, 10);
      chb("force off", 1'h0, frc);
      chb("unforced stall", 1'h0, s_tr);
      $display("done force");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      clk_in = 1'h0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      {rst_b_in, unb_fault, panel, wr, rd} = 5'h0;
      {lvl, ratio, unb_peak, unb_elapsed_delay_pct, tstamp, addr, wdata} = 120'h0;
      fails = 0;
      n_tests = 0;
      repeat (20) @(posedge clk_in);
      rst_b_in <= 1'h1;
      t_regs();
      t_fixed();
      t_inverse();
      t_soft();
      t_log();
      t_force();
      complete_run();
   end
   // About 18000 cycles expected
   initial begin
      repeat (60000) @(posedge clk_in);
      fails++;
      complete_run();
   end
endmodule // tb_top
